// ---- hdl/capture_pkg.sv ----
package capture_pkg;

  // sizes fixed by the device
  localparam int NUM_CH     = 9;
  localparam int CNT_W      = 16;
  localparam int NUM_SYNC   = 30;
  localparam int NUM_CLK    = 6;
  localparam int ADDR_W     = 12;
  localparam int PTR_W      = 2;

  localparam logic [2:0] FIFO_DEPTH = 3'h4;

  // register offsets inside one channel window, channel number in paddr[7:4]
  localparam logic [3:0] OFF_CON1 = 4'h0;
  localparam logic [3:0] OFF_CON2 = 4'h4;
  localparam logic [3:0] OFF_BUF  = 4'h8;
  localparam logic [3:0] OFF_CNT  = 4'hc;
  localparam int         CH_LSB   = 4;
  localparam int         PAGE_LSB = 8;

  // capture_control_one fields
  localparam int CON1_CLK_LSB = 10;
  localparam int CON1_INT_LSB = 5;
  localparam int CON1_OVF_BIT = 4;
  localparam int CON1_BNE_BIT = 3;
  localparam int CON1_MODE_LSB = 0;

  // capture_control_two fields
  localparam int CON2_CASC_BIT  = 8;
  localparam int CON2_TRIG_BIT  = 7;
  localparam int CON2_TSTAT_BIT = 6;
  localparam int CON2_SYNC_LSB  = 0;

  // capture_mode_select codes
  localparam logic [2:0] MODE_OFF    = 3'h0;
  localparam logic [2:0] MODE_EDGE   = 3'h1;
  localparam logic [2:0] MODE_RISE   = 3'h3;
  localparam logic [2:0] MODE_RISE4  = 3'h4;
  localparam logic [2:0] MODE_RISE16 = 3'h5;

  // last prescaler count before a divided capture
  localparam logic [3:0] PRESC_LAST4  = 4'h3;
  localparam logic [3:0] PRESC_LAST16 = 4'hf;

  localparam logic [4:0] SYNC_NONE = 5'h00;
  localparam logic [4:0] SYNC_MAX  = 5'h1e;
  localparam logic [15:0] CNT_TOP  = 16'hffff;

  typedef struct packed {
    logic [2:0] clk_sel;   // counter_clock_select
    logic [1:0] int_sel;   // interrupt_interval_select
    logic [2:0] mode;      // capture_mode_select
  } con1_t;

  typedef struct packed {
    logic       cascade;   // cascade_enable
    logic       trig_mode; // trigger_mode_select
    logic [4:0] sync_sel;  // sync_source_select
  } con2_t;

  localparam con1_t CON1_RESET = '0;
  localparam con2_t CON2_RESET = '0;

endpackage

// ---- hdl/capture_store.sv ----
`timescale 1ns/1ps
// four-word store for captured counter values, registered read port
module capture_store (
  input  wire logic        mclk,    // system clock
  input  wire logic        wr_en,   // write strobe
  input  wire logic [1:0]  wr_addr, // write slot
  input  wire logic [15:0] wr_data, // value to store
  input  wire logic [1:0]  rd_addr, // read slot
  output logic      [15:0] rd_data  // registered read value
);

  logic [15:0] mem [4];

  // no reset: contents only matter once written
  // write-through so a value pushed into an empty store reads back at once
  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= (wr_en && wr_addr == rd_addr) ? wr_data : mem[rd_addr];
  end

endmodule

// ---- hdl/input_capture_timer.sv ----
`timescale 1ns/1ps
// Contract
// - free-running counter counts up and wraps from ffff to 0000
// - each capture event stores present 16-bit counter value into the buffer unless it is full
// - capture buffer is a four-deep first-in first-out store
// - synchronous mode runs with the clock and clears counter on sync event
// - trigger mode holds counter until selected sync event, then runs
// - sync select zero and trigger bit clear gives free-running mode
// - nonzero sync select chooses the sync or trigger source
// - nonzero sync select: trigger bit one is trigger, zero is synchronous
// - sync select zero with trigger bit set waits for software trigger_status
// - thirty selectable sync or trigger sources per module
// - six selectable counter clock sources per module
// - adjacent odd and even modules combine into one 32-bit channel
// - odd module gives low half, even module gives high half
// - low half rollover increments the high half by one
// - cascade needs cascade_enable set in both modules of the pair
// - nine independent capture modules, each with an event output
// - buffer_not_empty high while unread values remain, cleared by hardware
// - capture on every rising edge, every transition, every 4th or 16th rise
// - cascaded synchronous pair held in reset until sync source enabled
// - even module of an active pair follows the odd module's timing
module input_capture_timer (
  input  wire logic        mclk,               // 25 MHz system clock
  input  wire logic        resetn,             // asynchronous reset, active low
  input  wire logic        psel,               // apb select
  input  wire logic        penable,            // apb enable
  input  wire logic        pwrite,             // apb direction, high writes
  input  wire logic [11:0] paddr,              // apb byte address
  input  wire logic [31:0] pwdata,             // apb write data
  output logic      [31:0] prdata,             // apb read data
  output logic             pready,             // apb ready
  output logic             pslverr,            // apb error on unmapped address
  input  wire logic [8:0]  capture_input,      // capture pins, asynchronous
  input  wire logic [5:0]  counter_clock_tick, // counter clock enables, one cycle
  input  wire logic [29:0] sync_event,         // on-chip sync events, one cycle
  input  wire logic [29:0] sync_source_enable, // on-chip sync sources running
  output logic      [8:0]  capture_int         // event pulse per module
);

  localparam int N = capture_pkg::NUM_CH;

  // one source out of thirty, zero and unused codes select nothing
  function automatic logic pick_source(input logic [29:0] v, input logic [4:0] s);
    logic hit;
    hit = 1'b0;
    if (s != capture_pkg::SYNC_NONE && s <= capture_pkg::SYNC_MAX)
    begin
      hit = v[s - 5'h01];
    end
    return hit;
  endfunction

  // apb address decode
  wire logic [3:0] acc_ch   = paddr[capture_pkg::CH_LSB +: 4];
  wire logic [3:0] acc_reg  = paddr[3:0];
  wire logic       addr_ok  = (paddr[capture_pkg::PAGE_LSB +: 4] == 4'h0)
                              && (acc_ch < 4'(N)) && (paddr[1:0] == 2'h0);
  wire logic       acc_done = psel & penable & pready;
  wire logic       wr_done  = acc_done & pwrite & addr_ok;
  wire logic       rd_done  = acc_done & ~pwrite & addr_ok;
  wire logic       first_ac = psel & penable & ~pready;

  // per channel state
  capture_pkg::con1_t con1_q    [N];
  capture_pkg::con2_t con2_q    [N];
  logic               trig_stat [N];
  logic               ovf       [N];
  logic [15:0]        cnt       [N];
  logic [15:0]        mem_q     [N];
  logic [2:0]         fill      [N];
  logic [1:0]         wptr      [N];
  logic [1:0]         rptr      [N];
  logic [1:0]         int_cnt   [N];
  logic [3:0]         presc     [N];
  logic               pin_s1    [N];
  logic               pin_s2    [N];
  logic               pin_prev  [N];
  logic               int_q     [N];

  // own timing decisions and effective ones after cascade slaving
  logic               pair_on   [N];
  logic               run_own   [N];
  logic               clr_own   [N];
  logic               inc_own   [N];
  logic               evt_own   [N];
  logic               run_e     [N];
  logic               clr_e     [N];
  logic               inc_e     [N];
  logic               evt_e     [N];
  logic [15:0]        con1_word [N];
  logic [15:0]        con2_word [N];

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : ch
      wire logic here     = (acc_ch == 4'(g));
      wire logic wr_con1  = wr_done & here & (acc_reg == capture_pkg::OFF_CON1);
      wire logic wr_con2  = wr_done & here & (acc_reg == capture_pkg::OFF_CON2);
      wire logic pop_req  = rd_done & here & (acc_reg == capture_pkg::OFF_BUF);
      wire logic [4:0] ss = con2_q[g].sync_sel;
      wire logic [2:0] cs = con1_q[g].clk_sel;
      wire logic [2:0] md = con1_q[g].mode;
      wire logic sel_zero = (ss == capture_pkg::SYNC_NONE);
      wire logic sync_hit = pick_source(sync_event, ss);
      wire logic src_on   = pick_source(sync_source_enable, ss);
      wire logic tick     = (cs < 3'(capture_pkg::NUM_CLK)) ? counter_clock_tick[cs] : 1'b0;
      wire logic trig_md  = con2_q[g].trig_mode;
      // nonzero source with trigger bit clear is synchronous mode
      wire logic sync_md  = ~sel_zero & ~trig_md;
      wire logic hold_rst = sync_md & pair_on[g] & ~src_on;
      wire logic hw_trig  = ~sel_zero & trig_md & sync_hit;
      wire logic rise     = pin_s2[g] & ~pin_prev[g];
      wire logic edge_any = pin_s2[g] ^ pin_prev[g];
      wire logic is_presc = (md == capture_pkg::MODE_RISE4) || (md == capture_pkg::MODE_RISE16);
      wire logic [3:0] presc_last = (md == capture_pkg::MODE_RISE4) ?
                                    capture_pkg::PRESC_LAST4 : capture_pkg::PRESC_LAST16;
      wire logic full     = (fill[g] == capture_pkg::FIFO_DEPTH);
      wire logic push     = evt_e[g] & ~full;
      wire logic pop      = pop_req & (fill[g] != 3'h0);
      // look ahead one slot so back-to-back pops never see a stale word
      wire logic [1:0] rd_next = pop ? rptr[g] + 2'h1 : rptr[g];

      // free mode always runs; trigger modes wait on trigger_status
      assign run_own[g] = (trig_md ? trig_stat[g] : 1'b1) & ~hold_rst;
      assign clr_own[g] = (sync_md & sync_hit) | hold_rst;
      assign inc_own[g] = tick & run_own[g] & ~clr_own[g];
      // capture selection, only while the counter may run
      assign evt_own[g] = run_own[g] & ((md == capture_pkg::MODE_EDGE && edge_any)
                          || (md == capture_pkg::MODE_RISE && rise)
                          || (is_presc && rise && presc[g] == presc_last));

      if (g % 2 == 1)
      begin : upper
        // even-numbered module: slaved to its odd partner when paired
        assign pair_on[g] = con2_q[g].cascade & con2_q[g-1].cascade;
        assign run_e[g]   = pair_on[g] ? run_e[g-1] : run_own[g];
        assign clr_e[g]   = pair_on[g] ? clr_e[g-1] : clr_own[g];
        assign inc_e[g]   = pair_on[g] ? (inc_e[g-1] && cnt[g-1] == capture_pkg::CNT_TOP)
                                       : inc_own[g];
        assign evt_e[g]   = pair_on[g] ? evt_e[g-1] : evt_own[g];
      end
      else
      begin : lower
        if (g + 1 < N)
        begin : paired
          assign pair_on[g] = con2_q[g].cascade & con2_q[g+1].cascade;
        end
        else
        begin : single
          assign pair_on[g] = 1'b0;
        end
        assign run_e[g] = run_own[g];
        assign clr_e[g] = clr_own[g];
        assign inc_e[g] = inc_own[g];
        assign evt_e[g] = evt_own[g];
      end

      assign con1_word[g] = {3'h0, con1_q[g].clk_sel, 3'h0, con1_q[g].int_sel,
                             ovf[g], (fill[g] != 3'h0), con1_q[g].mode};
      assign con2_word[g] = {7'h00, con2_q[g].cascade, con2_q[g].trig_mode,
                             trig_stat[g], 1'b0, con2_q[g].sync_sel};
      assign capture_int[g] = int_q[g];

      // software control registers
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
        begin
          con1_q[g] <= capture_pkg::CON1_RESET;
          con2_q[g] <= capture_pkg::CON2_RESET;
        end
        else
        begin
          if (wr_con1)
          begin
            con1_q[g] <= '{clk_sel: pwdata[capture_pkg::CON1_CLK_LSB +: 3],
                           int_sel: pwdata[capture_pkg::CON1_INT_LSB +: 2],
                           mode:    pwdata[capture_pkg::CON1_MODE_LSB +: 3]};
          end
          if (wr_con2)
          begin
            con2_q[g] <= '{cascade:   pwdata[capture_pkg::CON2_CASC_BIT],
                           trig_mode: pwdata[capture_pkg::CON2_TRIG_BIT],
                           sync_sel:  pwdata[capture_pkg::CON2_SYNC_LSB +: 5]};
          end
        end
      end

      // trigger_status and overflow: a hardware set beats a software clear
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
        begin
          trig_stat[g] <= 1'b0;
          ovf[g]       <= 1'b0;
        end
        else
        begin
          trig_stat[g] <= (wr_con2 ? pwdata[capture_pkg::CON2_TSTAT_BIT] : trig_stat[g])
                          | hw_trig;
          ovf[g] <= (wr_con1 ? (ovf[g] & pwdata[capture_pkg::CON1_OVF_BIT]) : ovf[g])
                    | (evt_e[g] & full);
        end
      end

      // dedicated counter, wraps naturally at the top
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
        begin
          cnt[g] <= 16'h0000;
        end
        else if (clr_e[g])
        begin
          cnt[g] <= 16'h0000;
        end
        else if (inc_e[g] && run_e[g])
        begin
          cnt[g] <= cnt[g] + 16'h0001;
        end
      end

      // pin synchroniser, then edge history and prescaler
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
        begin
          pin_s1[g]   <= 1'b0;
          pin_s2[g]   <= 1'b0;
          pin_prev[g] <= 1'b0;
          presc[g]    <= 4'h0;
        end
        else
        begin
          pin_s1[g]   <= capture_input[g];
          pin_s2[g]   <= pin_s1[g];
          pin_prev[g] <= pin_s2[g];
          if (!is_presc)
          begin
            presc[g] <= 4'h0;
          end
          else if (rise && run_own[g])
          begin
            presc[g] <= (presc[g] == presc_last) ? 4'h0 : presc[g] + 4'h1;
          end
        end
      end

      // buffer pointers and fill level; a full buffer drops the value
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
        begin
          wptr[g] <= 2'h0;
          rptr[g] <= 2'h0;
          fill[g] <= 3'h0;
        end
        else
        begin
          if (push)
          begin
            wptr[g] <= wptr[g] + 2'h1;
          end
          if (pop)
          begin
            rptr[g] <= rptr[g] + 2'h1;
          end
          case ({push, pop})
            2'b10:   fill[g] <= fill[g] + 3'h1;
            2'b01:   fill[g] <= fill[g] - 3'h1;
            default: fill[g] <= fill[g];
          endcase
        end
      end

      // event pulse every int_sel+1 captures of this module
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
        begin
          int_cnt[g] <= 2'h0;
          int_q[g]   <= 1'b0;
        end
        else
        begin
          int_q[g] <= evt_e[g] && (int_cnt[g] == con1_q[g].int_sel);
          if (evt_e[g])
          begin
            int_cnt[g] <= (int_cnt[g] == con1_q[g].int_sel) ? 2'h0 : int_cnt[g] + 2'h1;
          end
        end
      end

      capture_store u_store (
        .mclk    (mclk),
        .wr_en   (push),
        .wr_addr (wptr[g]),
        .wr_data (cnt[g]),
        .rd_addr (rd_next),
        .rd_data (mem_q[g])
      );
    end
  endgenerate

  // read mux; buffer data comes from the store's registered port
  logic [15:0] rd_value;
  always_comb
  begin
    rd_value = 16'h0000;
    if (addr_ok)
    begin
      case (acc_reg)
        capture_pkg::OFF_CON1: rd_value = con1_word[acc_ch];
        capture_pkg::OFF_CON2: rd_value = con2_word[acc_ch];
        capture_pkg::OFF_BUF:  rd_value = mem_q[acc_ch];
        capture_pkg::OFF_CNT:  rd_value = cnt[acc_ch];
        default:               rd_value = 16'h0000;
      endcase
    end
  end

  // one wait state gives the store time to present the oldest entry
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= first_ac;
      pslverr <= first_ac & ~addr_ok;
      if (first_ac)
      begin
        prdata <= {16'h0000, rd_value};
      end
    end
  end

endmodule

// ---- tb/capture_checker.sv ----
`timescale 1ns/1ps
// port-level watch on the register bus and the event pulses
module capture_checker (
  input wire logic        mclk,        // system clock
  input wire logic        resetn,      // reset, active low
  input wire logic        psel,        // apb select
  input wire logic        penable,     // apb enable
  input wire logic        pwrite,      // apb direction
  input wire logic [11:0] paddr,       // apb address
  input wire logic [31:0] prdata,      // apb read data
  input wire logic        pready,      // apb ready
  input wire logic        pslverr,     // apb error
  input wire logic [8:0]  capture_int,  // event pulses
  input wire logic [8:0]  capture_input // capture pins
);
  // address outside the nine windows or not word aligned
  wire unmapped = paddr[11:8] != 4'h0 || paddr[7:4] > 4'h8 || paddr[1:0] != 2'h0;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // access always lasts two cycles, so a slow ready shows up here
  a_ready_two: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not on second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  a_ready_req: assert property (pready |-> psel && penable)
    else $error("ready without an access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_bad_err: assert property (pready && unmapped |-> pslverr)
    else $error("unmapped access not refused");
  a_good_ok: assert property (pready && !unmapped |-> !pslverr)
    else $error("mapped access refused");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  // unslaved modules only pulse three edges after an edge on their own pin
  a_int_pulse: assert property (
    (capture_int & 9'h155) != 9'h0
    |-> ((capture_int & 9'h155)
         & ($past(capture_input, 3) ~^ $past(capture_input, 4))) == 9'h000)
    else $error("event pulse without a pin edge");
  a_reset_quiet: assert property ($rose(resetn) |-> !pready && capture_int == 9'h000)
    else $error("outputs active right after reset");

  c_write: cover property (pready && pwrite && !pslverr);
  c_read: cover property (pready && !pwrite && !pslverr);
  c_refused: cover property (pslverr);
  c_event: cover property (capture_int != 9'h0);
endmodule

bind input_capture_timer capture_checker i_chk (
  .mclk, .resetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .capture_int,
  .capture_input
);

// ---- tb/pulse_source.sv ----
`timescale 1ns/1ps
// external pulse source: one high pulse of the asked width per request
module pulse_source (
  input  wire logic       mclk,   // system clock
  input  wire logic       resetn, // reset, active low
  input  wire logic [8:0] start,  // one-cycle request per pin
  input  wire logic [3:0] width,  // extra high cycles
  output logic      [8:0] pins    // capture pins, low when idle
);
  logic [3:0] left;

  // pins driven from the mclk domain; the dut still resynchronises them
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      pins <= 9'h000;
      left <= 4'h0;
    end
    else if (start != 9'h000)
    begin
      pins <= start;
      left <= width;
    end
    else if (left != 4'h0)
      left <= left - 4'h1;
    else
      pins <= 9'h000;
endmodule

// ---- tb/input_capture_dedicated_timer_tb.sv ----
`timescale 1ns/1ps
module input_capture_dedicated_timer_tb;
  logic        mclk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, t0, e, q[$];
  integer      seed;
  logic [8:0]  capture_input, capture_int, start;
  logic [5:0]  counter_clock_tick;
  logic [29:0] sync_event, sync_source_enable;
  logic [3:0]  width;
  int          mismatches, n_checks, n_int, k, s;
  int          mode_exp[5] = '{32, 16, 4, 1, 4};
  logic [15:0] mode_val[5] = '{16'h0001, 16'h0003, 16'h0004, 16'h0005, 16'h0063};

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // event pulses of module 4, for the divider checks
  always @(posedge mclk)
    if (capture_int[4] === 1'b1)
      n_int <= n_int + 1;

  input_capture_timer i_dut (
    .mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .capture_input, .counter_clock_tick, .sync_event, .sync_source_enable,
    .capture_int
  );
  pulse_source i_src (.mclk, .resetn, .start, .width, .pins(capture_input));

  function automatic logic [11:0] ad(input int m, input logic [3:0] off);
    return {4'h0, 4'(m), off};
  endfunction

  function automatic logic bad(input logic [11:0] a);
    return a[11:8] != 4'h0 || a[7:4] > 4'h8 || a[1:0] != 2'h0;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] x);
    n_checks++;
    if (got !== x)
    begin
      mismatches++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, x);
    end
  endtask

  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    e = prdata;
    chk({31'h0, pslverr}, {31'h0, bad(a)});
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      mismatches++;
      close_out();
    end
  endtask

  task automatic wr(input int m, input logic [3:0] off, input logic [31:0] d);
    apb(1'b1, ad(m, off), d);
  endtask

  task automatic rd(input int m, input logic [3:0] off, input logic [31:0] x);
    apb(1'b0, ad(m, off), 32'h0);
    chk(e, x);
  endtask

  // n ticks of counter clock source c; source 0 is tallied in t0
  task automatic tk(input int c, input int n);
    if (c == 0)
      t0 += 32'(n);
    repeat (n)
    begin
      @(posedge mclk);
      counter_clock_tick <= 6'(1 << c);
    end
    @(posedge mclk);
    counter_clock_tick <= 6'h00;
  endtask

  // one pin pulse of random width, then time for the edge to land
  task automatic pulse(input int g);
    @(posedge mclk);
    start <= 9'(1 << g);
    width <= 4'($random(seed) & 3) + 4'h1;
    @(posedge mclk);
    start <= 9'h000;
    repeat (12) @(posedge mclk);
  endtask

  task automatic sev(input int n);
    @(posedge mclk);
    sync_event <= 30'(1) << (n - 1);
    @(posedge mclk);
    sync_event <= 30'h0;
  endtask

  initial
  begin
    seed = 32'hcd01;
    {psel, penable, pwrite, resetn} = 4'h0;
    {paddr, pwdata, start, width, sync_event, counter_clock_tick} = '0;
    sync_source_enable = '1;
    {t0, n_int, mismatches, n_checks} = '0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd(4, capture_pkg::OFF_CON1, 32'h0);
    rd(8, capture_pkg::OFF_CON2, 32'h0);
    apb(1'b0, 12'h090, 32'h0);
    chk(e, 32'h0);
    apb(1'b1, 12'h102, 32'h1);
    // five captures into a four-deep store, counter frozen between ticks
    wr(3, capture_pkg::OFF_CON1, 32'h3);
    for (int i = 0; i < 5; i++)
    begin
      q.push_back(t0);
      pulse(3);
      tk(0, 1 + ($random(seed) & 7));
    end
    rd(3, capture_pkg::OFF_CON1, 32'h1b);
    for (int i = 0; i < 4; i++)
      rd(3, capture_pkg::OFF_BUF, q[i]);
    rd(3, capture_pkg::OFF_CON1, 32'h13);
    wr(3, capture_pkg::OFF_CON1, 32'h3);
    rd(3, capture_pkg::OFF_CON1, 32'h3);
    // the four capturing modes and one interrupt interval
    for (int m = 0; m < 5; m++)
    begin
      wr(4, capture_pkg::OFF_CON1, {16'h0, mode_val[m]});
      n_int = 0;
      repeat (16) pulse(4);
      chk(32'(n_int), 32'(mode_exp[m]));
    end
    // each counter clock source, with a foreign source ticking first
    s = int'(t0);
    for (int c = 0; c < 6; c++)
    begin
      wr(2, capture_pkg::OFF_CON1, 32'(c) << 10);
      tk((c + 1) % 6, 3);
      k = 1 + ($random(seed) & 7);
      tk(c, k);
      s += k;
      rd(2, capture_pkg::OFF_CNT, 32'(s));
    end
    rd(8, capture_pkg::OFF_CNT, t0);
    // hardware trigger from a random source
    s = 1 + ({$random(seed)} % 30);
    wr(5, capture_pkg::OFF_CON2, 32'h80 | 32'(s));
    k = int'(t0);
    tk(0, 4);
    sev(s % 30 + 1);
    tk(0, 2);
    rd(5, capture_pkg::OFF_CNT, 32'(k));
    sev(s);
    rd(5, capture_pkg::OFF_CON2, 32'hc0 | 32'(s));
    tk(0, 3);
    rd(5, capture_pkg::OFF_CNT, 32'(k + 3));
    // software trigger, then synchronous clear from the same source
    wr(6, capture_pkg::OFF_CON2, 32'h80);
    k = int'(t0);
    tk(0, 3);
    rd(6, capture_pkg::OFF_CNT, 32'(k));
    wr(6, capture_pkg::OFF_CON2, 32'hc0);
    tk(0, 2);
    rd(6, capture_pkg::OFF_CNT, 32'(k + 2));
    wr(7, capture_pkg::OFF_CON2, 32'(s));
    tk(0, 3);
    sev(s);
    tk(0, 2);
    rd(7, capture_pkg::OFF_CNT, 32'h2);
    // cascaded pair on source 30, held while that source is off
    sync_source_enable <= 30'h0;
    wr(1, capture_pkg::OFF_CON2, 32'h19e);
    wr(0, capture_pkg::OFF_CON2, 32'h11e);
    wr(0, capture_pkg::OFF_CON1, 32'h3);
    tk(0, 3);
    rd(0, capture_pkg::OFF_CNT, 32'h0);
    sync_source_enable <= 30'h3fffffff;
    sev(30);
    tk(0, 65535);
    rd(0, capture_pkg::OFF_CNT, 32'hffff);
    rd(1, capture_pkg::OFF_CNT, 32'h0);
    tk(0, 1);
    rd(0, capture_pkg::OFF_CNT, 32'h0);
    rd(1, capture_pkg::OFF_CNT, 32'h1);
    pulse(0);
    rd(0, capture_pkg::OFF_BUF, 32'h0);
    rd(1, capture_pkg::OFF_BUF, 32'h1);
    close_out();
  end
endmodule
